/* File: rtl/core_seq_pkg.sv */
package core_seq_pkg;
    localparam int CLK_MHZ = 200;
    localparam int BLANK_TIME_US = 20;
    localparam int BLANK_CYCLES = BLANK_TIME_US * CLK_MHZ;
    localparam int VID_LSB_UV = 12500;
    localparam int SLEW_UV_PER_US = 1000;
    localparam int STEP_CYCLES = (VID_LSB_UV * CLK_MHZ) / SLEW_UV_PER_US;
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] BLANK_LAST = CNT_W'(BLANK_CYCLES - 1);
    localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

    localparam int VID_W = 7;
    localparam int NUM_DAC = 3;
    localparam int NUM_CORE = 2;
    localparam int FIELD_STRIDE = 8;
    typedef logic [VID_W-1:0] vid_t;
    typedef vid_t [NUM_DAC-1:0] dacVec_t;
    localparam vid_t VID_ZERO = 7'h00;
    localparam vid_t VID_ONE = 7'h01;
    // Two-bit boot code to DAC code, index 3 first
    localparam vid_t [3:0] BOOT_VID_TABLE = {7'h40, 7'h50, 7'h58, 7'h60};
    localparam dacVec_t DAC_ZERO = 21'h00_0000;

    localparam logic [31:0] ADDR_SERIAL_VID = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
    localparam logic [31:0] ADDR_DAC = 32'h0000_0008;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_FAULT_BIT = 4;
    localparam int STAT_UVLO_BIT = 5;
    localparam int STAT_SERIAL_BIT = 6;
    localparam int STAT_DEBUG_BIT = 7;
    localparam int STAT_OVP_EN_BIT = 8;
    localparam int STAT_STRAP_BIT = 9;
    localparam int STAT_PG_PIN_BIT = 10;
    localparam int STAT_BOOT_STORED_BIT = 11;
    localparam int STAT_OV_LSB = 12;

    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_REF_UP = 3'b001,
        ST_SOFT_START = 3'b010,
        ST_BOOT_WAIT = 3'b011,
        ST_RUN = 3'b100,
        ST_SOFT_CHIP_ENABLE_N = 3'b101,
        ST_CHIP_ENABLE_N_WAIT = 3'b110,
        ST_LATCHED = 3'b111
    } seqState_e;

    typedef enum logic [1:0] {
        GATE_OFF = 2'b00,
        GATE_SWITCH = 2'b01,
        GATE_LOW_ON = 2'b10
    } gateMode_e;

    typedef struct packed {
        logic chipEnableN;
        logic systemPowerOkIn;
        logic serialVidClock;
        logic serialVidData;
        logic referenceOk;
        logic planeStrapSensePin;
        logic protTiedHigh;
        logic protTiedLow;
        logic supplyAboveUvlo;
        logic supplyBelowClear;
        logic powerGoodPin;
        logic [NUM_CORE-1:0] pgOver;
        logic [NUM_CORE-1:0] pgUnder;
        logic [NUM_CORE-1:0] ovAboveDac;
        logic [NUM_CORE-1:0] ovAboveFixed;
        logic [NUM_CORE-1:0] inRegulation;
        logic [NUM_CORE-1:0] uvTrip;
    } pinIn_s;
    localparam int PIN_W = $bits(pinIn_s);
endpackage

/* File: rtl/core_supply_sequencer.sv */
module core_supply_sequencer
    import core_seq_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic chipEnableN,
    input wire logic systemPowerOkIn,
    input wire logic serialVidClock,
    input wire logic serialVidData,
    input wire logic referenceOk,
    input wire logic planeStrapSensePin,
    input wire logic protectionModePinHigh,
    input wire logic protectionModePinLow,
    input wire logic supplyAboveUvlo,
    input wire logic supplyBelowClear,
    input wire logic [NUM_CORE-1:0] pgOver,
    input wire logic [NUM_CORE-1:0] pgUnder,
    input wire logic [NUM_CORE-1:0] overvoltageAboveDac,
    input wire logic [NUM_CORE-1:0] overvoltageAboveFixed,
    input wire logic [NUM_CORE-1:0] inRegulation,
    input wire logic [NUM_CORE-1:0] undervoltageTrip,
    input wire logic powerGoodIn,
    output logic powerGoodOut,
    output logic powerGoodOeN,
    output gateMode_e [NUM_CORE-1:0] phaseGate,
    output logic [NUM_CORE-1:0] dischargeEn,
    output logic referenceEn,
    output logic nbBufferEn,
    output dacVec_t dacLevel
);
    pinIn_s pinRaw;
    pinIn_s pin;
    pinIn_s pinPrev;
    logic [PIN_W-1:0] syncA_ff, syncB_ff, syncC_ff, filt_ff, prev_ff, nxt_filt;

    seqState_e state_ff, nxt_state;
    dacVec_t target_ff, nxt_target, dac_ff, nxt_dac;
    dacVec_t bootLive_ff, nxt_bootLive, bootVid_ff, nxt_bootVid, svi_ff, nxt_svi;
    logic [CNT_W-1:0] timer_ff, nxt_timer, step_ff, nxt_step;
    logic [CNT_W-1:0] blank_ff, nxt_blank, holdCnt_ff, nxt_holdCnt;
    logic strap_ff, nxt_strap, bootStored_ff, nxt_bootStored;
    logic serialMode_ff, nxt_serialMode, debugHold_ff, nxt_debugHold;
    logic [1:0] codeAtFall_ff, nxt_codeAtFall;
    logic faultLatch_ff, nxt_faultLatch, uvloLatch_ff, nxt_uvloLatch;
    logic [NUM_CORE-1:0] ovFault_ff, nxt_ovFault, down_ff, nxt_down;
    logic hold_ff, nxt_hold, pgLow_ff, nxt_pgLow;
    gateMode_e [NUM_CORE-1:0] gate_ff, nxt_gate;
    logic [NUM_CORE-1:0] discharge_ff, nxt_discharge;
    logic refEn_ff, nxt_refEn, nbEn_ff, nxt_nbEn;
    logic wrPend_ff, nxt_wrPend;
    logic [31:0] wrAddr_ff, nxt_wrAddr, rdata_ff, nxt_rdata, readWord;

    logic enabled, pokRise, pokFall, ovpEnabled, debugMode, coreSlewing, atTarget;
    logic converting, faultHit, uvloTrip, windowBad, blanked, addrPhase, slewActive;
    logic [1:0] vidCode;
    logic [NUM_CORE-1:0] ovHit, ovSide;
    logic [31:0] statusWord;

    function automatic logic [31:0] packVid(input dacVec_t v);
        logic [31:0] w;
        w = WORD_ZERO;
        for (int k = 0; k < NUM_DAC; k++) begin
            w[k*FIELD_STRIDE +: VID_W] = v[k];
        end
        return w;
    endfunction

    function automatic dacVec_t unpackVid(input logic [31:0] w);
        dacVec_t v;
        v = DAC_ZERO;
        for (int k = 0; k < NUM_DAC; k++) begin
            v[k] = w[k*FIELD_STRIDE +: VID_W];
        end
        return v;
    endfunction

    // Pin capture: three stages, a change counts once stages two and three agree
    always_comb begin
        pinRaw.chipEnableN = chipEnableN;
        pinRaw.systemPowerOkIn = systemPowerOkIn;
        pinRaw.serialVidClock = serialVidClock;
        pinRaw.serialVidData = serialVidData;
        pinRaw.referenceOk = referenceOk;
        pinRaw.planeStrapSensePin = planeStrapSensePin;
        pinRaw.protTiedHigh = protectionModePinHigh;
        pinRaw.protTiedLow = protectionModePinLow;
        pinRaw.supplyAboveUvlo = supplyAboveUvlo;
        pinRaw.supplyBelowClear = supplyBelowClear;
        pinRaw.powerGoodPin = powerGoodIn;
        pinRaw.pgOver = pgOver;
        pinRaw.pgUnder = pgUnder;
        pinRaw.ovAboveDac = overvoltageAboveDac;
        pinRaw.ovAboveFixed = overvoltageAboveFixed;
        pinRaw.inRegulation = inRegulation;
        pinRaw.uvTrip = undervoltageTrip;
    end

    for (genvar gi = 0; gi < PIN_W; gi++) begin : g_filt
        assign nxt_filt[gi] = (syncB_ff[gi] == syncC_ff[gi]) ? syncC_ff[gi] : filt_ff[gi];
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            syncA_ff <= '0;
            syncB_ff <= '0;
            syncC_ff <= '0;
            filt_ff <= '0;
            prev_ff <= '0;
        end else begin
            syncA_ff <= pinRaw;
            syncB_ff <= syncA_ff;
            syncC_ff <= syncB_ff;
            filt_ff <= nxt_filt;
            prev_ff <= filt_ff;
        end
    end

    assign pin = pinIn_s'(filt_ff);
    assign pinPrev = pinIn_s'(prev_ff);
    assign enabled = pin.chipEnableN;
    assign pokRise = pin.systemPowerOkIn & ~pinPrev.systemPowerOkIn;
    assign pokFall = ~pin.systemPowerOkIn & pinPrev.systemPowerOkIn;
    assign ovpEnabled = pin.protTiedLow & ~pin.protTiedHigh;
    assign debugMode = ~pin.protTiedLow & ~pin.protTiedHigh;
    assign vidCode = {pin.serialVidClock, pin.serialVidData};
    assign coreSlewing = (dac_ff[0] != target_ff[0]) | (dac_ff[1] != target_ff[1]);
    assign atTarget = dac_ff == target_ff;
    assign converting = (state_ff == ST_SOFT_START) | (state_ff == ST_BOOT_WAIT)
        | (state_ff == ST_RUN);
    assign slewActive = converting | (state_ff == ST_SOFT_CHIP_ENABLE_N);
    assign ovHit = {NUM_CORE{ovpEnabled}}
        & ((down_ff & pin.ovAboveFixed) | (~down_ff & pin.ovAboveDac));
    assign faultHit = converting & ~faultLatch_ff & ((|ovHit) | (|pin.uvTrip));
    assign ovSide = strap_ff ? {NUM_CORE{|ovHit}} : ovHit;
    assign uvloTrip = ~pin.supplyAboveUvlo & (state_ff != ST_OFF) & (state_ff != ST_LATCHED);
    assign windowBad = (|pin.pgUnder) | (|(pin.pgOver & ~down_ff));

    // Sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_target = target_ff;
        nxt_timer = timer_ff;
        nxt_strap = strap_ff;
        nxt_bootLive = bootLive_ff;
        nxt_bootVid = bootVid_ff;
        nxt_bootStored = bootStored_ff;
        nxt_serialMode = serialMode_ff;
        nxt_debugHold = debugHold_ff;
        nxt_codeAtFall = codeAtFall_ff;
        unique case (state_ff)
            ST_OFF: begin
                nxt_serialMode = 1'b0;
                nxt_debugHold = 1'b0;
                nxt_target = DAC_ZERO;
                if (enabled && pin.supplyAboveUvlo && !faultLatch_ff && !uvloLatch_ff) begin
                    nxt_state = ST_REF_UP;
                end
            end
            ST_REF_UP: begin
                if (pin.referenceOk) begin
                    nxt_strap = pin.planeStrapSensePin;
                    nxt_bootLive = {NUM_DAC{BOOT_VID_TABLE[vidCode]}};
                    nxt_target = {NUM_DAC{BOOT_VID_TABLE[vidCode]}};
                    nxt_state = ST_SOFT_START;
                end
            end
            ST_SOFT_START: begin
                nxt_timer = CNT_ZERO;
                if (atTarget) begin
                    nxt_state = ST_BOOT_WAIT;
                end
            end
            ST_BOOT_WAIT: begin
                nxt_timer = timer_ff + CNT_ONE;
                if (timer_ff == BLANK_LAST) begin
                    nxt_state = ST_RUN;
                    if (!bootStored_ff) begin
                        nxt_bootVid = bootLive_ff;
                        nxt_bootStored = 1'b1;
                    end
                end
            end
            ST_RUN: begin
                if (pokFall) begin
                    nxt_serialMode = 1'b0;
                    nxt_debugHold = 1'b1;
                    nxt_codeAtFall = vidCode;
                    nxt_target = bootVid_ff;
                end else if (pokRise) begin
                    nxt_serialMode = 1'b1;
                end else if (serialMode_ff) begin
                    nxt_target = svi_ff;
                end else if (debugMode && (!debugHold_ff || vidCode != codeAtFall_ff)) begin
                    nxt_debugHold = 1'b0;
                    nxt_target = {NUM_DAC{BOOT_VID_TABLE[vidCode]}};
                end
            end
            ST_SOFT_CHIP_ENABLE_N: begin
                nxt_target = DAC_ZERO;
                nxt_timer = CNT_ZERO;
                if (dac_ff == DAC_ZERO) begin
                    nxt_state = ST_CHIP_ENABLE_N_WAIT;
                end
            end
            ST_CHIP_ENABLE_N_WAIT: begin
                nxt_timer = timer_ff + CNT_ONE;
                if (timer_ff == BLANK_LAST) begin
                    nxt_state = faultLatch_ff ? ST_LATCHED : ST_OFF;
                end
            end
            ST_LATCHED: begin
                nxt_target = DAC_ZERO;
                if (!faultLatch_ff && !uvloLatch_ff) begin
                    nxt_state = ST_OFF;
                end
            end
        endcase
        if (uvloTrip) begin
            nxt_state = ST_LATCHED;
            nxt_bootStored = 1'b0;
        end else if (!enabled && (converting || state_ff == ST_REF_UP)) begin
            nxt_state = ST_SOFT_CHIP_ENABLE_N;
        end else if (faultHit) begin
            nxt_state = ST_SOFT_CHIP_ENABLE_N;
        end
    end

    // Latches and downward-move flags; a new event wins over a clear
    always_comb begin
        nxt_faultLatch = (faultLatch_ff & enabled & ~pin.supplyBelowClear) | faultHit;
        nxt_ovFault = (ovFault_ff & {NUM_CORE{enabled & ~pin.supplyBelowClear}})
            | (faultHit ? ovSide : '0);
        nxt_uvloLatch = (uvloLatch_ff & ~pin.supplyBelowClear) | uvloTrip;
        for (int i = 0; i < NUM_CORE; i++) begin
            nxt_down[i] = (down_ff[i] & ~((dac_ff[i] == target_ff[i]) & pin.inRegulation[i]))
                | (nxt_target[i] < dac_ff[i]);
        end
    end

    // DAC slew at one code step per step period
    always_comb begin
        nxt_dac = dac_ff;
        nxt_step = CNT_ZERO;
        if (!slewActive) begin
            nxt_dac = DAC_ZERO;
        end else if (step_ff != STEP_LAST) begin
            nxt_step = step_ff + CNT_ONE;
        end else begin
            for (int k = 0; k < NUM_DAC; k++) begin
                if (dac_ff[k] < target_ff[k]) begin
                    nxt_dac[k] = dac_ff[k] + VID_ONE;
                end else if (dac_ff[k] > target_ff[k]) begin
                    nxt_dac[k] = dac_ff[k] - VID_ONE;
                end
            end
        end
    end

    // Power-good
    assign blanked = coreSlewing | (blank_ff != CNT_ZERO);
    always_comb begin
        nxt_blank = blank_ff;
        nxt_hold = hold_ff;
        nxt_holdCnt = holdCnt_ff;
        if (state_ff == ST_RUN && coreSlewing) begin
            nxt_blank = BLANK_LAST;
        end else if (blank_ff != CNT_ZERO) begin
            nxt_blank = blank_ff - CNT_ONE;
        end
        if (state_ff != ST_RUN) begin
            nxt_hold = 1'b0;
        end else if (pokFall || (hold_ff && (windowBad || coreSlewing))) begin
            nxt_hold = 1'b1;
            nxt_holdCnt = BLANK_LAST;
        end else if (hold_ff && holdCnt_ff == CNT_ZERO) begin
            nxt_hold = 1'b0;
        end else if (hold_ff) begin
            nxt_holdCnt = holdCnt_ff - CNT_ONE;
        end
        if (!enabled) begin
            nxt_pgLow = 1'b1;
        end else if (state_ff != ST_RUN) begin
            nxt_pgLow = 1'b1;
        end else if (hold_ff || pokFall) begin
            nxt_pgLow = 1'b1;
        end else if (blanked) begin
            nxt_pgLow = 1'b0;
        end else begin
            nxt_pgLow = windowBad;
        end
    end

    // Drivers, discharge switches, reference
    always_comb begin
        for (int i = 0; i < NUM_CORE; i++) begin
            if (nxt_uvloLatch) begin
                nxt_gate[i] = GATE_OFF;
            end else if (nxt_ovFault[i]) begin
                nxt_gate[i] = GATE_LOW_ON;
            end else if (nxt_state inside {ST_SOFT_START, ST_BOOT_WAIT, ST_RUN, ST_SOFT_CHIP_ENABLE_N}) begin
                nxt_gate[i] = GATE_SWITCH;
            end else begin
                nxt_gate[i] = GATE_OFF;
            end
        end
        nxt_discharge = {NUM_CORE{nxt_state inside {ST_OFF, ST_CHIP_ENABLE_N_WAIT, ST_LATCHED}}};
        nxt_refEn = nxt_state inside {ST_REF_UP, ST_SOFT_START, ST_BOOT_WAIT, ST_RUN,
            ST_SOFT_CHIP_ENABLE_N, ST_CHIP_ENABLE_N_WAIT};
        nxt_nbEn = nxt_state inside {ST_SOFT_START, ST_BOOT_WAIT, ST_RUN, ST_SOFT_CHIP_ENABLE_N,
            ST_CHIP_ENABLE_N_WAIT};
    end

    // AHB-Lite slave, zero wait states
    always_comb begin
        statusWord = WORD_ZERO;
        statusWord[STAT_STATE_LSB +: 3] = state_ff;
        statusWord[STAT_FAULT_BIT] = faultLatch_ff;
        statusWord[STAT_UVLO_BIT] = uvloLatch_ff;
        statusWord[STAT_SERIAL_BIT] = serialMode_ff;
        statusWord[STAT_DEBUG_BIT] = debugMode;
        statusWord[STAT_OVP_EN_BIT] = ovpEnabled;
        statusWord[STAT_STRAP_BIT] = strap_ff;
        statusWord[STAT_PG_PIN_BIT] = pin.powerGoodPin;
        statusWord[STAT_BOOT_STORED_BIT] = bootStored_ff;
        statusWord[STAT_OV_LSB +: NUM_CORE] = ovFault_ff;
        unique case (haddr)
            ADDR_SERIAL_VID: readWord = packVid(svi_ff);
            ADDR_STATUS: readWord = statusWord;
            ADDR_DAC: readWord = packVid(dac_ff);
            default: readWord = WORD_ZERO;
        endcase
        addrPhase = hsel & hready & htrans[HTRANS_ACTIVE_BIT];
        nxt_wrPend = addrPhase & hwrite & (hsize == HSIZE_WORD);
        nxt_wrAddr = addrPhase ? haddr : wrAddr_ff;
        nxt_rdata = (addrPhase && !hwrite) ? readWord : rdata_ff;
        nxt_svi = svi_ff;
        if (state_ff == ST_RUN && pokRise) begin
            nxt_svi = target_ff;
        end else if (wrPend_ff && wrAddr_ff == ADDR_SERIAL_VID && serialMode_ff
                && pin.systemPowerOkIn) begin
            nxt_svi = unpackVid(hwdata);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= ST_OFF;
            target_ff <= DAC_ZERO;
            dac_ff <= DAC_ZERO;
            bootLive_ff <= DAC_ZERO;
            bootVid_ff <= DAC_ZERO;
            svi_ff <= DAC_ZERO;
            timer_ff <= CNT_ZERO;
            step_ff <= CNT_ZERO;
            blank_ff <= CNT_ZERO;
            holdCnt_ff <= CNT_ZERO;
            strap_ff <= 1'b0;
            bootStored_ff <= 1'b0;
            serialMode_ff <= 1'b0;
            debugHold_ff <= 1'b0;
            codeAtFall_ff <= 2'h0;
            faultLatch_ff <= 1'b0;
            uvloLatch_ff <= 1'b0;
            ovFault_ff <= '0;
            down_ff <= '0;
            hold_ff <= 1'b0;
            pgLow_ff <= 1'b1;
            gate_ff <= {NUM_CORE{GATE_OFF}};
            discharge_ff <= '0;
            refEn_ff <= 1'b0;
            nbEn_ff <= 1'b0;
            wrPend_ff <= 1'b0;
            wrAddr_ff <= WORD_ZERO;
            rdata_ff <= WORD_ZERO;
        end else begin
            state_ff <= nxt_state;
            target_ff <= nxt_target;
            dac_ff <= nxt_dac;
            bootLive_ff <= nxt_bootLive;
            bootVid_ff <= nxt_bootVid;
            svi_ff <= nxt_svi;
            timer_ff <= nxt_timer;
            step_ff <= nxt_step;
            blank_ff <= nxt_blank;
            holdCnt_ff <= nxt_holdCnt;
            strap_ff <= nxt_strap;
            bootStored_ff <= nxt_bootStored;
            serialMode_ff <= nxt_serialMode;
            debugHold_ff <= nxt_debugHold;
            codeAtFall_ff <= nxt_codeAtFall;
            faultLatch_ff <= nxt_faultLatch;
            uvloLatch_ff <= nxt_uvloLatch;
            ovFault_ff <= nxt_ovFault;
            down_ff <= nxt_down;
            hold_ff <= nxt_hold;
            pgLow_ff <= nxt_pgLow;
            gate_ff <= nxt_gate;
            discharge_ff <= nxt_discharge;
            refEn_ff <= nxt_refEn;
            nbEn_ff <= nxt_nbEn;
            wrPend_ff <= nxt_wrPend;
            wrAddr_ff <= nxt_wrAddr;
            rdata_ff <= nxt_rdata;
        end
    end

    // Open-drain: the pin is only ever pulled low
    assign powerGoodOut = 1'b0;
    assign powerGoodOeN = ~pgLow_ff;
    assign phaseGate = gate_ff;
    assign dischargeEn = discharge_ff;
    assign referenceEn = refEn_ff;
    assign nbBufferEn = nbEn_ff;
    assign dacLevel = dac_ff;
    assign hrdata = rdata_ff;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
endmodule

/* File: tb/core_supply_sequencer_checker.sv */
module core_supply_sequencer_checker
    import core_seq_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic chipEnableN,
    input wire logic systemPowerOkIn,
    input wire logic referenceOk,
    input wire logic supplyAboveUvlo,
    input wire logic protectionModePinHigh,
    input wire logic protectionModePinLow,
    input wire logic [NUM_CORE-1:0] overvoltageAboveDac,
    input wire logic powerGoodOeN,
    input wire gateMode_e [NUM_CORE-1:0] phaseGate,
    input wire logic [NUM_CORE-1:0] dischargeEn,
    input wire logic referenceEn,
    input wire dacVec_t dacLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_uvlo;
        $fell(supplyAboveUvlo) && referenceEn |-> ##[1:6] phaseGate == 4'h0 && dischargeEn == 2'h3;
    endproperty
    a_uvlo: assert property (p_uvlo) else $error("uvlo off missing");
    property p_pg_en; $fell(chipEnableN) |-> ##[1:6] !powerGoodOeN; endproperty
    a_pg_en: assert property (p_pg_en) else $error("pg not low");
    logic [CNT_W-1:0] lag_ff, nxt_lag;
    always_comb begin
        nxt_lag = (referenceOk && !dischargeEn[0] && dacLevel == DAC_ZERO)
            ? lag_ff + CNT_ONE : CNT_ZERO;
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lag_ff <= CNT_ZERO;
        end else begin
            lag_ff <= nxt_lag;
        end
    end
    property p_boot; lag_ff < CNT_W'(STEP_CYCLES + 20); endproperty
    a_boot: assert property (p_boot) else $error("no ramp");
    property p_pok;
        $fell(systemPowerOkIn) && chipEnableN && referenceEn |-> ##[1:6] (!powerGoodOeN) [*8];
    endproperty
    a_pok: assert property (p_pok) else $error("pg not held");
    property p_pg_up; $rose(powerGoodOeN) && !systemPowerOkIn |-> $past(dacLevel, 250) == dacLevel;
    endproperty
    a_pg_up: assert property (p_pg_up) else $error("pg early");
    property p_dis;
        $rose(dischargeEn[0]) && !chipEnableN && supplyAboveUvlo |-> dacLevel == DAC_ZERO;
    endproperty
    a_dis: assert property (p_dis) else $error("discharge early");
    property p_off;
        $fell(referenceEn) && !chipEnableN && supplyAboveUvlo
            |-> $past(dacLevel, 250) == DAC_ZERO && dischargeEn == 2'h3 && phaseGate == 4'h0;
    endproperty
    a_off: assert property (p_off) else $error("bad shutdown");
    property p_ovp;
        $rose(overvoltageAboveDac[0]) && protectionModePinLow && !protectionModePinHigh
            && referenceEn && dacLevel != DAC_ZERO |-> ##[1:8] phaseGate[0] == GATE_LOW_ON;
    endproperty
    a_ovp: assert property (p_ovp) else $error("ov gate missing");
    c_ov: cover property (phaseGate[0] == GATE_LOW_ON);
    c_dis: cover property ($rose(dischargeEn[0]));
    c_off: cover property ($fell(referenceEn));
endmodule
bind core_supply_sequencer core_supply_sequencer_checker chk (.*);

/* File: tb/cpu_host_model.sv */
module cpu_host_model
    import core_seq_pkg::*;
#(
    parameter int HOLD = 10 * CLK_MHZ,
    parameter int RESET_DELAY = 1000 * CLK_MHZ
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] bootCode,
    input wire logic enableReq,
    input wire logic powerOkReq,
    output logic chipEnableN,
    output logic systemPowerOkIn,
    output logic serialVidClock,
    output logic serialVidData,
    output logic cpuResetN
);
    timeunit 1ns;
    timeprecision 1ps;
    int codeCnt_ff;
    int pokCnt_ff;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            codeCnt_ff <= 0;
            pokCnt_ff <= 0;
            chipEnableN <= 1'b0;
            systemPowerOkIn <= 1'b0;
            {serialVidClock, serialVidData} <= 2'h0;
            cpuResetN <= 1'b0;
        end else begin
            if (!systemPowerOkIn || pokCnt_ff >= HOLD) begin
                {serialVidClock, serialVidData} <= bootCode;
            end
            codeCnt_ff <= ({serialVidClock, serialVidData} != bootCode) ? 0
                : codeCnt_ff + int'(codeCnt_ff < HOLD);
            chipEnableN <= enableReq && (chipEnableN || codeCnt_ff >= HOLD);
            systemPowerOkIn <= powerOkReq;
            pokCnt_ff <= systemPowerOkIn ? pokCnt_ff + int'(pokCnt_ff < RESET_DELAY) : 0;
            cpuResetN <= systemPowerOkIn && pokCnt_ff >= RESET_DELAY;
        end
    end
endmodule

/* File: tb/core_supply_sequence_fault_logic_tb.sv */
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
`define WT(c, n) begin k = 0; while (!(c) && k < (n)) begin @(posedge clk); k++; end \
    if (!(c)) begin num_errors++; give_verdict(); end end
module core_supply_sequence_fault_logic_tb
    import core_seq_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, hsel, hwrite, hready, referenceOk, planeStrapSensePin, supplyAboveUvlo;
    logic protectionModePinHigh, protectionModePinLow, enableReq, powerOkReq, chipEnableN;
    logic systemPowerOkIn, serialVidClock, serialVidData, hreadyout, hresp, powerGoodOut;
    logic powerGoodOeN, powerGoodIn, referenceEn, nbBufferEn;
    logic [1:0] htrans, bootCode, pgUnder, overvoltageAboveDac, dischargeEn;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    gateMode_e [NUM_CORE-1:0] phaseGate;
    dacVec_t dacLevel;
    int num_errors, compares, k;
    assign hready = hreadyout;
    assign powerGoodIn = powerGoodOeN | powerGoodOut;
    core_supply_sequencer dut (.supplyBelowClear(1'b0), .pgOver(2'h0), .inRegulation(2'h3),
        .overvoltageAboveFixed(2'h0), .undervoltageTrip(2'h0), .*);
    cpu_host_model host (.cpuResetN(), .*);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task give_verdict;
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        `WT(hready === 1'b1, 50)
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge clk);
        `WT(hready === 1'b1, 50)
        rd = hrdata;
    endtask
    task start_up(input logic s);
        planeStrapSensePin <= s;
        enableReq <= 1'b1;
        `WT(referenceEn === 1'b1, 2200)
        referenceOk <= 1'b1;
        `WT(dacLevel[0] == VID_ONE, 2600)
    endtask
    task t_idle;
        pgUnder <= 2'h1;
        repeat (8) @(posedge clk);
        `CHK(powerGoodIn, 1'b0)
        pgUnder <= 2'h0;
        for (int i = 0; i < 3; i++) begin
            protectionModePinHigh <= (i == 0);
            protectionModePinLow <= (i == 2);
            repeat (8) @(posedge clk);
            bus(1'b0, ADDR_STATUS, WORD_ZERO);
            `CHK(rd[STAT_OVP_EN_BIT:STAT_DEBUG_BIT], 2'(i))
        end
        bus(1'b1, ADDR_SERIAL_VID, 32'h0000_007f);
        bus(1'b0, ADDR_SERIAL_VID, WORD_ZERO);
        `CHK(rd, WORD_ZERO)
        bus(1'b0, 32'h0000_000c, WORD_ZERO);
        `CHK(rd, WORD_ZERO)
    endtask
    task t_shutdown;
        start_up(1'b0);
        `WT(dacLevel[0] == 7'h02, 2600)
        `CHK(k, STEP_CYCLES)
        `CHK(dacLevel, {3{7'h02}})
        enableReq <= 1'b0;
        referenceOk <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK(powerGoodIn, 1'b0)
        `WT(dacLevel == DAC_ZERO, 6000)
        `WT(referenceEn === 1'b0, 4100)
        `CHK(k > BLANK_CYCLES - 3 && k < BLANK_CYCLES + 3, 1'b1)
        `CHK({phaseGate, dischargeEn}, 6'h03)
    endtask
    task t_ov;
        start_up(1'b0);
        overvoltageAboveDac <= 2'h1;
        `WT(phaseGate[0] == GATE_LOW_ON, 8)
        `CHK(phaseGate[1] !== GATE_LOW_ON, 1'b1)
        bus(1'b0, ADDR_STATUS, WORD_ZERO);
        `CHK(rd[STAT_FAULT_BIT], 1'b1)
        `WT(referenceEn === 1'b0, 9000)
        `CHK(nbBufferEn, 1'b0)
        overvoltageAboveDac <= 2'h0;
        enableReq <= 1'b0;
        referenceOk <= 1'b0;
        repeat (8) @(posedge clk);
        bus(1'b0, ADDR_STATUS, WORD_ZERO);
        `CHK(rd[STAT_FAULT_BIT], 1'b0)
    endtask
    task t_uvlo;
        start_up(1'b1);
        powerOkReq <= 1'b1;
        repeat (8) @(posedge clk);
        powerOkReq <= 1'b0;
        repeat (8) @(posedge clk);
        supplyAboveUvlo <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK({phaseGate, dischargeEn}, 6'h03)
        bus(1'b0, ADDR_STATUS, WORD_ZERO);
        `CHK(rd[STAT_STATE_LSB+:3], ST_LATCHED)
    endtask
    initial begin
        num_errors = 0;
        compares = 0;
        {sys_rst, hsel, hwrite, referenceOk, planeStrapSensePin, protectionModePinHigh} = 6'h20;
        {enableReq, powerOkReq, protectionModePinLow, supplyAboveUvlo} = 4'h3;
        {htrans, pgUnder, overvoltageAboveDac} = 6'h00;
        bootCode = 2'h3;
        hsize = HSIZE_WORD;
        haddr = WORD_ZERO;
        hwdata = WORD_ZERO;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        t_idle();
        t_shutdown();
        t_ov();
        t_uvlo();
        give_verdict();
    end
endmodule
